// file: hw/pst_pkg.sv
package pst_pkg;
  localparam logic [7:0] OFF_HALT_LEVELS = 8'h00;
  localparam logic [7:0] OFF_HALT_SOURCE = 8'h04;
  localparam logic [7:0] OFF_TB_LOW      = 8'h08;
  localparam logic [7:0] OFF_TB_HIGH     = 8'h0c;
  localparam logic [7:0] OFF_PH_LOW      = 8'h10;
  localparam logic [7:0] OFF_PH_HIGH     = 8'h14;
  localparam logic [7:0] OFF_DC_LOW      = 8'h18;
  localparam logic [7:0] OFF_DC_HIGH     = 8'h1c;
  localparam logic [7:0] OFF_HALT_CTRL   = 8'h20;
  localparam logic [7:0] OFF_PWM_CTRL    = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h2c;

  localparam logic [7:0] RST_HALT_LEVELS = 8'h00;
  localparam logic [7:0] RST_HALT_SOURCE = 8'h00;
  localparam logic [7:0] RST_TB_LOW      = 8'h00;
  localparam logic [7:0] RST_TB_HIGH     = 8'h01;
  localparam logic [7:0] RST_PH          = 8'h00;
  localparam logic [7:0] RST_DC          = 8'h00;

  localparam logic [7:0] MASK_LEVELS_FULL  = 8'h3f;
  localparam logic [7:0] MASK_LEVELS_SHORT = 8'h03;
  localparam logic [7:0] MASK_SOURCE       = 8'h8e;

  localparam int SRC_PIN_BIT  = 7;
  localparam int SRC_CMP3_BIT = 3;
  localparam int SRC_CMP2_BIT = 2;
  localparam int SRC_CMP1_BIT = 1;

  localparam int CTRL_EVENT_BIT    = 7;
  localparam int CTRL_ENABLE_BIT   = 6;
  localparam int CTRL_RESTART_BIT  = 5;
  localparam int CTRL_OVERRIDE_BIT = 0;
  localparam logic [7:0] MASK_CTRL = 8'he1;

  localparam int PWM_RUN_BIT      = 0;
  localparam int PWM_DUTY_SRC_BIT = 1;

  localparam int IRQ_HALT_BIT   = 0;
  localparam int IRQ_FALL_BIT   = 1;
  localparam int IRQ_PERIOD_BIT = 2;
  localparam int IRQ_WIDTH      = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pst_pkg

// file: hw/pst_timebase.sv
`timescale 1ns/1ps
module pst_timebase
  import pst_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic             i_run,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_load_value,
  input  wire logic [WIDTH-1:0] i_duty,
  input  wire logic [WIDTH-1:0] i_phase,
  output logic      [WIDTH-1:0] o_count,
  output logic                  o_duty_match,
  output logic                  o_wrap
);
  initial begin
    if (WIDTH < 2) $error("pst_timebase WIDTH too small");
  end

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire              at_top = &count_reg;

  // Software load wins over counting so a written byte is never lost
  assign count_next = i_load ? i_load_value :
                      (i_run ? (at_top ? i_phase : count_reg + 1'b1) : count_reg);
  assign o_count      = count_reg;
  assign o_duty_match = i_run && (count_reg == i_duty);
  assign o_wrap       = i_run && at_top && !i_load;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      count_reg <= {RST_TB_HIGH, RST_TB_LOW};
    end else begin
      count_reg <= count_next;
    end
  end

  a_count_step: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_run && !i_load && !at_top) |=> (count_reg == $past(count_reg) + 1'b1))
    else $error("Time base did not step by one");
endmodule : pst_timebase

// file: hw/pst_regs.sv
`timescale 1ns/1ps
// What this block does
// - While shutdown is asserted each output A..F drives its own level bit, bit 0 for A up to bit 5 for F.
// - On the second instance only the level bits for A and B exist; C..F read zero and drive zero.
// - Source bit 7 set lets the external input pin trigger shutdown; clear, the pin is ignored.
// - Source bits 3, 2, 1 let synchronized comparators 3, 2, 1 trigger shutdown; clear means never.
// - The time base counter is 16 bits and its low byte is read and written at the low register.
// - The counter's high byte is read and written at the high register.
// - A 16-bit phase count is held, its low byte at the phase low register.
// - The phase high byte sits at the phase high register.
// - A 16-bit duty count is held, its low byte at the duty low register.
// - The duty high byte sits at its own duty high register.
// - With shutdown enabled and override clear, any selected source at one forces shutdown state and sets the halt flag.
// - With shutdown enabled and override set, the levels are forced without setting the halt flag.
// - With duty-edge selection enabled and the time base running, a falling-edge event happens when counter equals duty count.
module pst_regs
  import pst_pkg::*;
#(
  parameter bit SECOND_INSTANCE = 1'b0,
  parameter int ADDR_WIDTH      = 8
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  i_external_halt_input,
  input  wire logic                  i_comparator1_synced,
  input  wire logic                  i_comparator2_synced,
  input  wire logic                  i_comparator3_synced,
  input  wire logic [5:0]            i_pwm_drive,
  output logic      [5:0]            o_pwm_out,
  output logic                       o_falling_edge_event,
  output logic                       o_period_event,
  output logic                       o_halt_active,
  output logic                       o_irq
);
  initial begin
    if (ADDR_WIDTH < 8) $error("pst_regs ADDR_WIDTH too small");
  end

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } pst_wr_state_t;

  function automatic logic [7:0] pst_merge(input logic [7:0] old_value, input logic [31:0] data,
                                           input logic [3:0] strb, input logic [7:0] keep);
    pst_merge = (strb[0] ? data[7:0] : old_value) & keep;
  endfunction : pst_merge

  localparam logic [7:0] LEVEL_KEEP = SECOND_INSTANCE ? MASK_LEVELS_SHORT : MASK_LEVELS_FULL;

  logic [7:0]           levels_reg;
  logic [7:0]           source_reg;
  logic [7:0]           ph_low_reg;
  logic [7:0]           ph_high_reg;
  logic [7:0]           dc_low_reg;
  logic [7:0]           dc_high_reg;
  logic [7:0]           ctrl_reg;
  logic [7:0]           ctrl_next;
  logic [1:0]           pwm_reg;
  logic [IRQ_WIDTH-1:0] status_reg;
  logic [IRQ_WIDTH-1:0] status_next;
  logic [IRQ_WIDTH-1:0] mask_reg;
  logic [5:0]           pwm_out_reg;
  logic                 fall_reg;
  logic                 period_reg;
  pst_wr_state_t        wr_state_reg;
  logic [1:0]           bresp_reg;
  logic                 rvalid_reg;
  logic [31:0]          rdata_reg;
  logic [1:0]           rresp_reg;
  logic [15:0]          tb_count;
  logic                 tb_match;
  logic                 tb_wrap;

  // Write channel: both address and data are taken in the same cycle
  wire                  wr_fire  = (wr_state_reg == WR_IDLE) && s_axi_awvalid && s_axi_wvalid;
  wire [7:0]            wr_addr  = s_axi_awaddr[7:0];
  wire                  wr_hit_levels = wr_fire && (wr_addr == OFF_HALT_LEVELS);
  wire                  wr_hit_source = wr_fire && (wr_addr == OFF_HALT_SOURCE);
  wire                  wr_hit_tb_low = wr_fire && (wr_addr == OFF_TB_LOW);
  wire                  wr_hit_tb_hi  = wr_fire && (wr_addr == OFF_TB_HIGH);
  wire                  wr_hit_ph_low = wr_fire && (wr_addr == OFF_PH_LOW);
  wire                  wr_hit_ph_hi  = wr_fire && (wr_addr == OFF_PH_HIGH);
  wire                  wr_hit_dc_low = wr_fire && (wr_addr == OFF_DC_LOW);
  wire                  wr_hit_dc_hi  = wr_fire && (wr_addr == OFF_DC_HIGH);
  wire                  wr_hit_ctrl   = wr_fire && (wr_addr == OFF_HALT_CTRL);
  wire                  wr_hit_pwm    = wr_fire && (wr_addr == OFF_PWM_CTRL);
  wire                  wr_hit_stat   = wr_fire && (wr_addr == OFF_IRQ_STATUS);
  wire                  wr_hit_mask   = wr_fire && (wr_addr == OFF_IRQ_MASK);
  wire                  wr_mapped     = wr_addr[1:0] == 2'b00 && wr_addr <= OFF_IRQ_MASK;

  // Shutdown source combination
  wire                  src_pin  = source_reg[SRC_PIN_BIT] && i_external_halt_input;
  wire                  src_cmp  = (source_reg[SRC_CMP1_BIT] && i_comparator1_synced) ||
                                   (source_reg[SRC_CMP2_BIT] && i_comparator2_synced) ||
                                   (source_reg[SRC_CMP3_BIT] && i_comparator3_synced);
  wire                  src_any  = src_pin || src_cmp;
  wire                  halt_en  = ctrl_reg[CTRL_ENABLE_BIT];
  wire                  override = halt_en && ctrl_reg[CTRL_OVERRIDE_BIT];
  wire                  trip     = halt_en && src_any && !ctrl_reg[CTRL_OVERRIDE_BIT];
  wire                  halted   = ctrl_reg[CTRL_EVENT_BIT] || override;
  wire [5:0]            level_bits = levels_reg[5:0] & LEVEL_KEEP[5:0];
  wire [5:0]            pwm_out_next = halted ? level_bits : i_pwm_drive;
  wire                  fall_next  = pwm_reg[PWM_DUTY_SRC_BIT] && tb_match;
  wire [15:0]           tb_load_value = wr_hit_tb_low ? {tb_count[15:8], pst_merge(tb_count[7:0], s_axi_wdata,
                                         s_axi_wstrb, 8'hff)} :
                                         {pst_merge(tb_count[15:8], s_axi_wdata, s_axi_wstrb, 8'hff),
                                          tb_count[7:0]};

  // Event bit: hardware set wins; restart mode clears it once the source is gone
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_hit_ctrl) begin
      ctrl_next = pst_merge(ctrl_reg, s_axi_wdata, s_axi_wstrb, MASK_CTRL);
    end
    if (ctrl_next[CTRL_RESTART_BIT] && !src_any && !wr_hit_ctrl) begin
      ctrl_next[CTRL_EVENT_BIT] = 1'b0;
    end
    if (trip) begin
      ctrl_next[CTRL_EVENT_BIT] = 1'b1;
    end
  end

  always_comb begin
    status_next = status_reg;
    if (wr_hit_stat && s_axi_wstrb[0]) begin
      status_next = status_reg & ~s_axi_wdata[IRQ_WIDTH-1:0];
    end
    status_next[IRQ_HALT_BIT]   = status_next[IRQ_HALT_BIT] | trip;
    status_next[IRQ_FALL_BIT]   = status_next[IRQ_FALL_BIT] | fall_next;
    status_next[IRQ_PERIOD_BIT] = status_next[IRQ_PERIOD_BIT] | tb_wrap;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      levels_reg  <= RST_HALT_LEVELS;
      source_reg  <= RST_HALT_SOURCE;
      ph_low_reg  <= RST_PH;
      ph_high_reg <= RST_PH;
      dc_low_reg  <= RST_DC;
      dc_high_reg <= RST_DC;
      ctrl_reg    <= 8'h00;
      pwm_reg     <= 2'b00;
      status_reg  <= '0;
      mask_reg    <= '0;
    end else begin
      if (wr_hit_levels) levels_reg  <= pst_merge(levels_reg, s_axi_wdata, s_axi_wstrb, LEVEL_KEEP);
      if (wr_hit_source) source_reg  <= pst_merge(source_reg, s_axi_wdata, s_axi_wstrb, MASK_SOURCE);
      if (wr_hit_ph_low) ph_low_reg  <= pst_merge(ph_low_reg, s_axi_wdata, s_axi_wstrb, 8'hff);
      if (wr_hit_ph_hi)  ph_high_reg <= pst_merge(ph_high_reg, s_axi_wdata, s_axi_wstrb, 8'hff);
      if (wr_hit_dc_low) dc_low_reg  <= pst_merge(dc_low_reg, s_axi_wdata, s_axi_wstrb, 8'hff);
      if (wr_hit_dc_hi)  dc_high_reg <= pst_merge(dc_high_reg, s_axi_wdata, s_axi_wstrb, 8'hff);
      if (wr_hit_pwm && s_axi_wstrb[0]) pwm_reg <= s_axi_wdata[1:0];
      if (wr_hit_mask && s_axi_wstrb[0]) mask_reg <= s_axi_wdata[IRQ_WIDTH-1:0];
      ctrl_reg   <= ctrl_next;
      status_reg <= status_next;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      pwm_out_reg <= 6'h00;
      fall_reg    <= 1'b0;
      period_reg  <= 1'b0;
    end else begin
      pwm_out_reg <= pwm_out_next;
      fall_reg    <= fall_next;
      period_reg  <= tb_wrap;
    end
  end

  pst_timebase #(
    .WIDTH (16)
  ) u_timebase (
    .i_ref_clk    (i_ref_clk),
    .i_reset      (i_reset),
    .i_run        (pwm_reg[PWM_RUN_BIT]),
    .i_load       (wr_hit_tb_low || wr_hit_tb_hi),
    .i_load_value (tb_load_value),
    .i_duty       ({dc_high_reg, dc_low_reg}),
    .i_phase      ({ph_high_reg, ph_low_reg}),
    .o_count      (tb_count),
    .o_duty_match (tb_match),
    .o_wrap       (tb_wrap)
  );

  // Bus write response
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_state_reg <= WR_IDLE;
      bresp_reg    <= RESP_OKAY;
    end else begin
      case (wr_state_reg)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= WR_RESP;
            bresp_reg    <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) wr_state_reg <= WR_IDLE;
        end
        default: wr_state_reg <= WR_IDLE;
      endcase
    end
  end

  // Bus read
  wire        rd_fire = s_axi_arvalid && !rvalid_reg;
  wire [7:0]  rd_addr = s_axi_araddr[7:0];
  wire        rd_mapped = rd_addr[1:0] == 2'b00 && rd_addr <= OFF_IRQ_MASK;
  wire [7:0]  rd_byte =
    (rd_addr == OFF_HALT_LEVELS) ? levels_reg :
    (rd_addr == OFF_HALT_SOURCE) ? source_reg :
    (rd_addr == OFF_TB_LOW)      ? tb_count[7:0] :
    (rd_addr == OFF_TB_HIGH)     ? tb_count[15:8] :
    (rd_addr == OFF_PH_LOW)      ? ph_low_reg :
    (rd_addr == OFF_PH_HIGH)     ? ph_high_reg :
    (rd_addr == OFF_DC_LOW)      ? dc_low_reg :
    (rd_addr == OFF_DC_HIGH)     ? dc_high_reg :
    (rd_addr == OFF_HALT_CTRL)   ? ctrl_reg :
    (rd_addr == OFF_PWM_CTRL)    ? {6'h00, pwm_reg} :
    (rd_addr == OFF_IRQ_STATUS)  ? {5'h00, status_reg} :
    (rd_addr == OFF_IRQ_MASK)    ? {5'h00, mask_reg} : 8'h00;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_byte};
      rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready        = wr_fire;
  assign s_axi_wready         = wr_fire;
  assign s_axi_bvalid         = wr_state_reg == WR_RESP;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = rd_fire;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rdata          = rdata_reg;
  assign s_axi_rresp          = rresp_reg;
  assign o_pwm_out            = pwm_out_reg;
  assign o_falling_edge_event = fall_reg;
  assign o_period_event       = period_reg;
  assign o_halt_active        = halted;
  assign o_irq                = |(status_reg & mask_reg);

  sequence s_trip;
    halt_en && !ctrl_reg[CTRL_OVERRIDE_BIT] && src_any;
  endsequence

  a_trip_sets_flag: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_trip |=> status_reg[IRQ_HALT_BIT] && ctrl_reg[CTRL_EVENT_BIT])
    else $error("Shutdown trip did not set flag");
  a_trip_levels: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_trip |=> ##1 (o_pwm_out == $past(level_bits)))
    else $error("Outputs not at shutdown levels");
  a_override_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (override && !status_reg[IRQ_HALT_BIT] && !(wr_hit_ctrl)) |=> !status_reg[IRQ_HALT_BIT])
    else $error("Override raised halt flag");
  a_override_drive: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    override |=> (o_pwm_out == $past(level_bits)))
    else $error("Override did not force levels");
  a_second_levels: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    SECOND_INSTANCE |-> (levels_reg[5:2] == 4'h0))
    else $error("Unimplemented level bits set");
  a_pin_ignored: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (!source_reg[SRC_PIN_BIT] && !src_cmp) |-> !trip)
    else $error("Pin tripped while disabled");
  a_cmp_trip: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (halt_en && !ctrl_reg[CTRL_OVERRIDE_BIT] && source_reg[SRC_CMP2_BIT] && i_comparator2_synced)
    |=> ctrl_reg[CTRL_EVENT_BIT])
    else $error("Comparator did not trip");
  a_duty_fall: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (pwm_reg[PWM_DUTY_SRC_BIT] && pwm_reg[PWM_RUN_BIT] && tb_count == {dc_high_reg, dc_low_reg})
    |=> o_falling_edge_event)
    else $error("Missing falling edge event");
  a_tb_high_rd: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (rd_fire && rd_addr == OFF_TB_HIGH) |=> (s_axi_rdata[7:0] == $past(tb_count[15:8])))
    else $error("Time base high read wrong");
  a_dc_high_wr: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (wr_hit_dc_hi && s_axi_wstrb[0]) |=> (dc_high_reg == $past(s_axi_wdata[7:0])))
    else $error("Duty high write lost");

  // Pins follow the levels for as long as shutdown holds, not only right after the trip
  a_halt_pins_held: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    halted |=> (o_pwm_out == $past(level_bits)))
    else $error("Outputs left shutdown levels");
  a_run_passthru: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !halted |=> (o_pwm_out == $past(i_pwm_drive)))
    else $error("Outputs not following drive");
  a_pin_trip: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (halt_en && !ctrl_reg[CTRL_OVERRIDE_BIT] && source_reg[SRC_PIN_BIT] && i_external_halt_input)
    |=> ctrl_reg[CTRL_EVENT_BIT])
    else $error("Input pin did not trip");
  a_cmp1_trip: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (halt_en && !ctrl_reg[CTRL_OVERRIDE_BIT] && source_reg[SRC_CMP1_BIT] && i_comparator1_synced)
    |=> ctrl_reg[CTRL_EVENT_BIT])
    else $error("Comparator one did not trip");
  a_cmp3_trip: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (halt_en && !ctrl_reg[CTRL_OVERRIDE_BIT] && source_reg[SRC_CMP3_BIT] && i_comparator3_synced)
    |=> ctrl_reg[CTRL_EVENT_BIT])
    else $error("Comparator three did not trip");
  a_source_bits: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (source_reg & ~MASK_SOURCE) == 8'h00)
    else $error("Unimplemented source bit set");
  // A clear racing a new trip must not lose the flag
  a_flag_set_wins: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (trip && wr_hit_stat) |=> status_reg[IRQ_HALT_BIT])
    else $error("Clear beat a new trip");
  a_duty_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !pwm_reg[PWM_DUTY_SRC_BIT] |=> !o_falling_edge_event)
    else $error("Falling edge while unselected");
  a_period_pulse: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    tb_wrap |=> o_period_event)
    else $error("Missing period event");
  a_write_answer: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    wr_fire |=> s_axi_bvalid)
    else $error("Write not answered");
  a_read_answer: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    rd_fire |=> s_axi_rvalid)
    else $error("Read not answered");
endmodule : pst_regs

// file: bench/pst_stage_model.sv
`timescale 1ns/1ps
module pst_stage_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic [3:0] i_trip,
  output logic            o_external_halt_input,
  output logic            o_comparator3_synced,
  output logic            o_comparator2_synced,
  output logic            o_comparator1_synced
);
  // Fault lines move only on the clock, since the comparator outputs are already synchronized
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      {o_external_halt_input, o_comparator3_synced, o_comparator2_synced, o_comparator1_synced} <= 4'h0;
    end else begin
      {o_external_halt_input, o_comparator3_synced, o_comparator2_synced, o_comparator1_synced} <= i_trip;
    end
  end
endmodule : pst_stage_model

// file: bench/pst_regs_test.sv
`timescale 1ns/1ps
`define check(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module pst_regs_test;
  import pst_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] rst; logic [7:0] wd; logic [7:0] rb; logic [1:0] rs;} pst_row_t;
  logic        i_ref_clk;
  logic        i_reset = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdata2, rd;
  logic [3:0]  s_axi_wstrb = 4'h1, trip = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        i_external_halt_input, i_comparator1_synced, i_comparator2_synced, i_comparator3_synced;
  logic [5:0]  i_pwm_drive = 6'h1a, o_pwm_out, pwm2;
  logic        o_falling_edge_event, o_period_event, o_halt_active, o_irq;
  int          failures, samples_checked, cyc, n, k;
  logic [7:0]  srcs [4] = '{8'h80, 8'h08, 8'h04, 8'h02};
  pst_row_t    rows [9] = '{
    '{OFF_HALT_LEVELS, 8'h00, 8'hff, 8'h3f, RESP_OKAY},
    '{OFF_HALT_SOURCE, 8'h00, 8'hff, 8'h8e, RESP_OKAY},
    '{OFF_TB_LOW,      8'h00, 8'h34, 8'h34, RESP_OKAY},
    '{OFF_TB_HIGH,     8'h01, 8'h12, 8'h12, RESP_OKAY},
    '{OFF_PH_LOW,      8'h00, 8'h56, 8'h56, RESP_OKAY},
    '{OFF_PH_HIGH,     8'h00, 8'h78, 8'h78, RESP_OKAY},
    '{OFF_DC_LOW,      8'h00, 8'h9a, 8'h9a, RESP_OKAY},
    '{OFF_DC_HIGH,     8'h00, 8'hbc, 8'hbc, RESP_OKAY},
    '{8'h30,           8'h00, 8'hff, 8'h00, RESP_SLVERR}};

  pst_regs #(.SECOND_INSTANCE(1'b0), .ADDR_WIDTH(8)) dut (
    .i_ref_clk, .i_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .i_external_halt_input, .i_comparator1_synced, .i_comparator2_synced, .i_comparator3_synced,
    .i_pwm_drive, .o_pwm_out, .o_falling_edge_event, .o_period_event, .o_halt_active, .o_irq);
  // Shadow of the reduced instance: same bus and faults, only read data and pins observed
  pst_regs #(.SECOND_INSTANCE(1'b1), .ADDR_WIDTH(8)) dut2 (
    .i_ref_clk, .i_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(rdata2), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
    .i_external_halt_input, .i_comparator1_synced, .i_comparator2_synced, .i_comparator3_synced,
    .i_pwm_drive, .o_pwm_out(pwm2), .o_falling_edge_event(), .o_period_event(), .o_halt_active(), .o_irq());
  pst_stage_model model (.i_ref_clk, .i_reset, .i_trip(trip), .o_external_halt_input(i_external_halt_input),
    .o_comparator3_synced(i_comparator3_synced), .o_comparator2_synced(i_comparator2_synced),
    .o_comparator1_synced(i_comparator1_synced));

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic pa, pw;
    @(posedge i_ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (pa && s_axi_awready === 1'b1) begin s_axi_awvalid <= 1'b0; pa = 1'b0; end
      if (pw && s_axi_wready === 1'b1) begin s_axi_wvalid <= 1'b0; pw = 1'b0; end
    end while (pa || pw);
    do @(posedge i_ref_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge i_ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge i_ref_clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic settle(input int c);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask : settle

  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    foreach (rows[i]) begin
      axi_rd(rows[i].a);
      if (rows[i].rs == RESP_OKAY) `check(rd, {24'h0, rows[i].rst})
    end
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].wd);
      `check(resp, rows[i].rs)
      axi_rd(rows[i].a);
      `check(resp, rows[i].rs)
      if (rows[i].rs == RESP_OKAY) `check(rd, {24'h0, rows[i].rb})
    end
    axi_rd(OFF_HALT_LEVELS);
    `check(rdata2[7:0], 8'h03)
    axi_wr(OFF_HALT_LEVELS, 8'h25);
    axi_wr(OFF_IRQ_MASK, 8'h01);
    axi_wr(OFF_HALT_CTRL, 8'h40);
    // Each source alone must trip, while every other source enabled must leave it ignored
    for (int i = 0; i < 4; i++) begin
      axi_wr(OFF_HALT_SOURCE, 8'h8e ^ srcs[i]);
      trip <= 4'b1000 >> i;
      settle(6);
      `check(o_halt_active, 1'b0)
      `check(o_pwm_out, 6'h1a)
      axi_wr(OFF_HALT_SOURCE, 8'h8e);
      k = 0;
      while (o_halt_active !== 1'b1 && k < 8) begin settle(1); k++; end
      settle(2);
      `check(o_pwm_out, 6'h25)
      `check(pwm2, 6'h01)
      `check(o_irq, 1'b1)
      axi_rd(OFF_IRQ_STATUS);
      `check(rd[0], 1'b1)
      axi_wr(OFF_IRQ_MASK, 8'h00);
      settle(1);
      `check(o_irq, 1'b0)
      axi_wr(OFF_IRQ_MASK, 8'h01);
      trip <= 4'h0;
      axi_wr(OFF_HALT_CTRL, 8'h40);
      axi_wr(OFF_IRQ_STATUS, 8'h01);
      settle(1);
      `check(o_irq, 1'b0)
    end
    axi_wr(OFF_HALT_CTRL, 8'h41);
    settle(3);
    `check(o_pwm_out, 6'h25)
    axi_rd(OFF_IRQ_STATUS);
    `check(rd[0], 1'b0)
    axi_wr(OFF_HALT_CTRL, 8'h01);
    settle(3);
    `check(o_pwm_out, 6'h1a)
    axi_wr(OFF_TB_HIGH, 8'h00);
    axi_wr(OFF_TB_LOW, 8'h00);
    axi_wr(OFF_DC_HIGH, 8'h00);
    axi_wr(OFF_DC_LOW, 8'h20);
    for (int m = 0; m < 2; m++) begin
      axi_wr(OFF_PWM_CTRL, 8'h00);
      axi_wr(OFF_TB_LOW, 8'h00);
      axi_wr(OFF_PWM_CTRL, m ? 8'h03 : 8'h01);
      n = 0;
      repeat (60) begin settle(1); n += (o_falling_edge_event === 1'b1); end
      `check(n, m)
    end
    // Counter still running: park it just below the top and count the wraps
    axi_wr(OFF_TB_HIGH, 8'hff);
    axi_wr(OFF_TB_LOW, 8'hf0);
    n = 0;
    repeat (40) begin settle(1); n += (o_period_event === 1'b1); end
    `check(n, 1)
    axi_rd(OFF_IRQ_STATUS);
    `check(rd[1], 1'b1)
    `check(rd[2], 1'b1)
    end_of_test();
  end
endmodule : pst_regs_test
